/* File: src/rtc_pkg.sv */
// Purpose: Shared constants for the 16-bit real-time counter.
// Assumes: Byte-wide register port, 4-bit byte address.
// Notes: Offsets are byte addresses on the register port.
package rtc_pkg;
    localparam logic [3:0] ADDR_DIV_CTRL = 4'h0;
    localparam logic [3:0] ADDR_SYNC_FLAG = 4'h1;
    localparam logic [3:0] ADDR_IRQ_LEVEL = 4'h2;
    localparam logic [3:0] ADDR_IRQ_FLAG = 4'h3;
    localparam logic [3:0] ADDR_HOLDING = 4'h4;
    localparam logic [3:0] ADDR_COUNT_LOW = 4'h8;
    localparam logic [3:0] ADDR_COUNT_HIGH = 4'h9;
    localparam logic [3:0] ADDR_TOP_LOW = 4'hA;
    localparam logic [3:0] ADDR_TOP_HIGH = 4'hB;
    localparam logic [3:0] ADDR_MATCH_LOW = 4'hC;
    localparam logic [3:0] ADDR_MATCH_HIGH = 4'hD;
    // Interrupt flag and level field positions.
    localparam int OVF_BIT = 0;
    localparam int MATCH_BIT = 1;
    localparam int OVF_LVL_LSB = 0;
    localparam int MATCH_LVL_LSB = 2;
    localparam int DIV_WIDTH = 3;
    // Vector word offsets of the two interrupt sources.
    localparam logic [7:0] OVERFLOW_VECTOR = 8'h00;
    localparam logic [7:0] MATCH_VECTOR = 8'h02;
    // Divider code that stops the counter.
    localparam logic [2:0] DIV_STOP = 3'h0;
    // Reference ticks from a system-side write until it takes effect.
    localparam logic [1:0] SYNC_TICKS = 2'h2;
    // Reset values.
    localparam logic [15:0] TOP_RESET = 16'hFFFF;
    localparam logic [15:0] MATCH_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    // Events dropped between emitted events when top is zero or one.
    localparam logic [1:0] EV_SKIP_TOP0 = 2'h2;
    localparam logic [1:0] EV_SKIP_TOP1 = 2'h1;
endpackage

/* File: src/rtc_core.sv */
// Purpose: 16-bit real-time counter with top and match compare, flags, events.
// Assumes: i_ref_clk is a slow reference sampled on i_clk; writes obey sync_pending.
// Notes: Register port is byte wide; read data appear one cycle after the strobe.
// Function
// - Count equals top: set overflow, clear count.
// - Top and match take effect after two ticks.
// - Count equals match sets the match flag.
// - Match above top never requests or events.
// - Top value held as high and low byte.
// - Match value held as high and low byte.
// - Count low register shows count bits 7:0.
// - Overflow vector 0x00, match vector 0x02.
// - Divider code stops or divides the reference.
// - Sync flag high while a write crosses.
// - Events thinned when top is zero or one.
// - Flags clear on vector ack or write-one.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module rtc_core (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ref_clk,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_ovf_vec_ack,
    input wire logic i_match_vec_ack,
    output logic [7:0] o_rdata,
    output logic o_irq,
    output logic [7:0] o_irq_vector,
    output logic o_ovf_event,
    output logic o_match_event,
    output logic o_sync_pending
);
    // Returns the divide ratio minus one for a divider code.
    function automatic logic [9:0] div_last(input logic [2:0] code);
        unique case (code)
            3'h1: div_last = 10'h000;
            3'h2: div_last = 10'h001;
            3'h3: div_last = 10'h007;
            3'h4: div_last = 10'h00F;
            3'h5: div_last = 10'h03F;
            3'h6: div_last = 10'h0FF;
            3'h7: div_last = 10'h3FF;
            default: div_last = 10'h000;
        endcase
    endfunction

    logic ref_q, ref_d;
    logic [9:0] pre_q, pre_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] top_q, top_d, top_sw_q, top_sw_d;
    logic [15:0] match_q, match_d, match_sw_q, match_sw_d;
    logic [15:0] cnt_sw_q, cnt_sw_d;
    logic [2:0] div_q, div_d, div_sw_q, div_sw_d;
    logic [3:0] lvl_q, lvl_d;
    logic [1:0] flag_q, flag_d;
    logic [7:0] temp_q, temp_d;
    logic [1:0] stage_q, stage_d;
    logic [3:0] pend_q, pend_d;
    logic [1:0] ev_ovf_q, ev_ovf_d, ev_match_q, ev_match_d;
    logic [7:0] rdata_q, rdata_d;
    logic irq_q, irq_d, ovf_ev_q, ovf_ev_d, match_ev_q, match_ev_d, sync_q, sync_d;
    logic [7:0] vec_q, vec_d;
    logic ref_tick, div_tick, ovf_hit, match_hit, apply;
    logic [1:0] ev_skip;

    assign ref_tick = i_ref_clk & ~ref_q;
    assign div_tick = ref_tick && (div_q != rtc_pkg::DIV_STOP) && (pre_q == div_last(div_q));
    assign apply = ref_tick && (stage_q == 2'h1);
    assign ovf_hit = div_tick && (cnt_q == top_q);
    assign match_hit = div_tick && (cnt_q == match_q) && (match_q <= top_q);
    assign ev_skip = (top_q == 16'h0000) ? rtc_pkg::EV_SKIP_TOP0 : rtc_pkg::EV_SKIP_TOP1;

    always_comb
    begin
        ref_d = i_ref_clk;
        pre_d = pre_q;
        cnt_d = cnt_q;
        top_d = top_q;
        match_d = match_q;
        div_d = div_q;
        top_sw_d = top_sw_q;
        match_sw_d = match_sw_q;
        cnt_sw_d = cnt_sw_q;
        div_sw_d = div_sw_q;
        lvl_d = lvl_q;
        flag_d = flag_q;
        temp_d = temp_q;
        stage_d = stage_q;
        pend_d = pend_q;
        ev_ovf_d = ev_ovf_q;
        ev_match_d = ev_match_q;
        rdata_d = 8'h00;
        ovf_ev_d = 1'b0;
        match_ev_d = 1'b0;
        // Prescaler runs on reference edges while the divider is not stopped.
        if (ref_tick && div_q != rtc_pkg::DIV_STOP)
            pre_d = div_tick ? 10'h000 : pre_q + 10'h001;
        if (div_tick)
            cnt_d = ovf_hit ? 16'h0000 : cnt_q + 16'h0001;
        // Events are thinned when top is too small for the crossing to keep up.
        if (ovf_hit && (top_q >= 16'h0002 || ev_ovf_q == ev_skip))
        begin
            ovf_ev_d = 1'b1;
            ev_ovf_d = 2'h0;
        end
        else if (ovf_hit)
            ev_ovf_d = ev_ovf_q + 2'h1;
        if (match_hit && (top_q >= 16'h0002 || ev_match_q == ev_skip))
        begin
            match_ev_d = 1'b1;
            ev_match_d = 2'h0;
        end
        else if (match_hit)
            ev_match_d = ev_match_q + 2'h1;
        // Crossing: staged values take effect on the second reference edge.
        if (apply)
        begin
            if (pend_q[0])
            begin
                cnt_d = cnt_sw_q;
                pre_d = 10'h000;
            end
            // A new divider restarts the prescaler so a stale phase cannot stretch a tick.
            if (pend_q[1])
            begin
                div_d = div_sw_q;
                pre_d = 10'h000;
            end
            if (pend_q[2])
                top_d = top_sw_q;
            if (pend_q[3])
                match_d = match_sw_q;
            pend_d = 4'h0;
            stage_d = 2'h0;
        end
        else if (ref_tick && stage_q != 2'h0)
            stage_d = stage_q - 2'h1;
        // Flag clears from software and vector acknowledge; a set wins.
        if (i_wr && i_addr == rtc_pkg::ADDR_IRQ_FLAG)
            flag_d = flag_q & ~i_wdata[1:0];
        if (i_ovf_vec_ack)
            flag_d[rtc_pkg::OVF_BIT] = 1'b0;
        if (i_match_vec_ack)
            flag_d[rtc_pkg::MATCH_BIT] = 1'b0;
        if (ovf_hit)
            flag_d[rtc_pkg::OVF_BIT] = 1'b1;
        if (match_hit)
            flag_d[rtc_pkg::MATCH_BIT] = 1'b1;
        // Low byte writes go to the holding byte; high byte writes commit the pair.
        if (i_wr)
        begin
            unique case (i_addr)
                rtc_pkg::ADDR_DIV_CTRL:
                begin
                    div_sw_d = i_wdata[rtc_pkg::DIV_WIDTH-1:0];
                    pend_d[1] = 1'b1;
                    stage_d = rtc_pkg::SYNC_TICKS;
                end
                rtc_pkg::ADDR_IRQ_LEVEL: lvl_d = i_wdata[3:0];
                rtc_pkg::ADDR_HOLDING,
                rtc_pkg::ADDR_COUNT_LOW,
                rtc_pkg::ADDR_TOP_LOW,
                rtc_pkg::ADDR_MATCH_LOW: temp_d = i_wdata;
                rtc_pkg::ADDR_COUNT_HIGH:
                begin
                    cnt_sw_d = {i_wdata, temp_q};
                    pend_d[0] = 1'b1;
                    stage_d = rtc_pkg::SYNC_TICKS;
                end
                rtc_pkg::ADDR_TOP_HIGH:
                begin
                    top_sw_d = {i_wdata, temp_q};
                    pend_d[2] = 1'b1;
                    stage_d = rtc_pkg::SYNC_TICKS;
                end
                rtc_pkg::ADDR_MATCH_HIGH:
                begin
                    match_sw_d = {i_wdata, temp_q};
                    pend_d[3] = 1'b1;
                    stage_d = rtc_pkg::SYNC_TICKS;
                end
                default: ;
            endcase
        end
        // Low byte reads latch the high byte in the holding byte.
        if (i_rd)
        begin
            unique case (i_addr)
                rtc_pkg::ADDR_DIV_CTRL: rdata_d = {5'h00, div_sw_q};
                rtc_pkg::ADDR_SYNC_FLAG: rdata_d = {7'h00, sync_q};
                rtc_pkg::ADDR_IRQ_LEVEL: rdata_d = {4'h0, lvl_q};
                rtc_pkg::ADDR_IRQ_FLAG: rdata_d = {6'h00, flag_q};
                rtc_pkg::ADDR_HOLDING: rdata_d = temp_q;
                rtc_pkg::ADDR_COUNT_LOW:
                begin
                    rdata_d = cnt_q[7:0];
                    temp_d = cnt_q[15:8];
                end
                rtc_pkg::ADDR_TOP_LOW:
                begin
                    rdata_d = top_sw_q[7:0];
                    temp_d = top_sw_q[15:8];
                end
                rtc_pkg::ADDR_MATCH_LOW:
                begin
                    rdata_d = match_sw_q[7:0];
                    temp_d = match_sw_q[15:8];
                end
                rtc_pkg::ADDR_COUNT_HIGH,
                rtc_pkg::ADDR_TOP_HIGH,
                rtc_pkg::ADDR_MATCH_HIGH: rdata_d = temp_q;
                default: rdata_d = 8'h00;
            endcase
        end
        sync_d = (pend_d != 4'h0);
        irq_d = ((flag_d[rtc_pkg::OVF_BIT] && lvl_q[rtc_pkg::OVF_LVL_LSB +: 2] != 2'h0)
                || (flag_d[rtc_pkg::MATCH_BIT] && lvl_q[rtc_pkg::MATCH_LVL_LSB +: 2] != 2'h0));
        // Overflow has the lower vector and is reported first.
        if (flag_d[rtc_pkg::OVF_BIT] && lvl_q[rtc_pkg::OVF_LVL_LSB +: 2] != 2'h0)
            vec_d = rtc_pkg::OVERFLOW_VECTOR;
        else
            vec_d = rtc_pkg::MATCH_VECTOR;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ref_q <= 1'b0;
            pre_q <= 10'h000;
            cnt_q <= rtc_pkg::COUNT_RESET;
            top_q <= rtc_pkg::TOP_RESET;
            match_q <= rtc_pkg::MATCH_RESET;
            div_q <= rtc_pkg::DIV_RESET;
            top_sw_q <= rtc_pkg::TOP_RESET;
            match_sw_q <= rtc_pkg::MATCH_RESET;
            cnt_sw_q <= rtc_pkg::COUNT_RESET;
            div_sw_q <= rtc_pkg::DIV_RESET;
            lvl_q <= rtc_pkg::LEVEL_RESET;
            flag_q <= 2'h0;
            temp_q <= 8'h00;
            stage_q <= 2'h0;
            pend_q <= 4'h0;
            ev_ovf_q <= 2'h0;
            ev_match_q <= 2'h0;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
            vec_q <= rtc_pkg::MATCH_VECTOR;
            ovf_ev_q <= 1'b0;
            match_ev_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            ref_q <= ref_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            top_q <= top_d;
            match_q <= match_d;
            div_q <= div_d;
            top_sw_q <= top_sw_d;
            match_sw_q <= match_sw_d;
            cnt_sw_q <= cnt_sw_d;
            div_sw_q <= div_sw_d;
            lvl_q <= lvl_d;
            flag_q <= flag_d;
            temp_q <= temp_d;
            stage_q <= stage_d;
            pend_q <= pend_d;
            ev_ovf_q <= ev_ovf_d;
            ev_match_q <= ev_match_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            vec_q <= vec_d;
            ovf_ev_q <= ovf_ev_d;
            match_ev_q <= match_ev_d;
            sync_q <= sync_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_irq = irq_q;
    assign o_irq_vector = vec_q;
    assign o_ovf_event = ovf_ev_q;
    assign o_match_event = match_ev_q;
    assign o_sync_pending = sync_q;

    ovf_wrap_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ovf_hit && !(apply && pend_q[0]) |=> cnt_q == 16'h0000 && flag_q[0])
        else $error("Count did not wrap to zero with overflow flag at top.");
    top_apply_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        apply && pend_q[2] |=> top_q == $past(top_sw_q) && !sync_q)
        else $error("Staged top value not applied on the crossing edge.");
    sync_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_wr && i_addr == rtc_pkg::ADDR_TOP_HIGH |=> sync_q && stage_q == 2'h2)
        else $error("Top write did not raise the sync flag.");
    match_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        div_tick && cnt_q == match_q && match_q <= top_q |=> flag_q[1])
        else $error("Match flag not set on equal count.");
    no_match_above_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        match_q > top_q && !apply |=> !o_match_event)
        else $error("Match event produced with match above top.");
    count_step_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        div_tick && cnt_q != top_q && !apply |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("Count did not advance on a divided tick.");
    div_stop_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        div_q == rtc_pkg::DIV_STOP && !apply |=> $stable(cnt_q))
        else $error("Count moved while the divider is stopped.");
    event_thin_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ovf_hit && top_q == 16'h0000 && ev_ovf_q != 2'h2 |=> !o_ovf_event)
        else $error("Overflow event not thinned with top at zero.");
    ack_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ovf_vec_ack && !ovf_hit |=> !flag_q[0])
        else $error("Overflow flag survived its vector acknowledge.");
    top_pair_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_wr && i_addr == rtc_pkg::ADDR_TOP_HIGH |=> top_sw_q == {$past(i_wdata), $past(temp_q)})
        else $error("Top value byte pair assembled wrongly.");
    match_pair_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_wr && i_addr == rtc_pkg::ADDR_MATCH_HIGH
        |=> match_sw_q == {$past(i_wdata), $past(temp_q)})
        else $error("Match value byte pair assembled wrongly.");
    count_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr == rtc_pkg::ADDR_COUNT_LOW
        |=> o_rdata == $past(cnt_q[7:0]) && temp_q == $past(cnt_q[15:8]))
        else $error("Count low read returned wrong data.");
    ovf_seen_c: cover property (@(posedge i_clk) disable iff (!i_resetn) ovf_hit ##1 o_irq);
    match_ev_c: cover property (@(posedge i_clk) disable iff (!i_resetn) o_match_event);
    apply_c: cover property (@(posedge i_clk) disable iff (!i_resetn) apply && pend_q[3]);
endmodule

/* File: test/tb_rtc16_period_compare.sv */
// Purpose: Self-checking bench for the 16-bit real-time counter register block.
// Assumes: Reference clock free-running, made from i_clk and changed just after its edges.
// Notes: Event spacing is measured in reference ticks between overflow pulses.
`timescale 1ns/10ps
module tb_rtc16_period_compare;
    localparam int CYC_MAX = 90000;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_ref_clk = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_ovf_vec_ack = 1'b0;
    logic i_match_vec_ack = 1'b0;
    logic [7:0] o_rdata;
    logic o_irq;
    logic [7:0] o_irq_vector;
    logic o_ovf_event;
    logic o_match_event;
    logic o_sync_pending;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    logic ref_d1 = 1'b0;
    logic [15:0] tick_n = 16'h0000;
    logic [15:0] gap = 16'h0000;
    int ovf_n = 0;
    int mat_n = 0;
    wire rise = i_ref_clk & ~ref_d1;

    rtc_core rtc_core_i (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_ref_clk(i_ref_clk),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_ovf_vec_ack(i_ovf_vec_ack), .i_match_vec_ack(i_match_vec_ack),
        .o_rdata(o_rdata), .o_irq(o_irq), .o_irq_vector(o_irq_vector),
        .o_ovf_event(o_ovf_event), .o_match_event(o_match_event),
        .o_sync_pending(o_sync_pending)
    );

    initial
    begin
        forever #2.5 i_clk = ~i_clk;
    end
    // The reference runs at a fifth of the system rate, two cycles high and three low.
    logic [2:0] ref_ph = 3'h0;
    always @(posedge i_clk)
    begin
        ref_ph <= (ref_ph == 3'h4) ? 3'h0 : ref_ph + 3'h1;
        i_ref_clk <= (ref_ph < 3'h2);
    end

    // Counts reference ticks between overflow events and tallies both event kinds.
    always @(posedge i_clk)
    begin
        ref_d1 <= i_ref_clk;
        if (o_ovf_event === 1'b1)
        begin
            gap <= tick_n + {15'h0000, rise};
            tick_n <= 16'h0000;
            ovf_n <= ovf_n + 1;
        end
        else
            tick_n <= tick_n + {15'h0000, rise};
        if (o_match_event === 1'b1)
            mat_n <= mat_n + 1;
        cyc <= cyc + 1;
        if (cyc == CYC_MAX)
        begin
            err_total = err_total + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk({8'h00, v}, {8'h00, e});
    endtask

    // Low byte goes first so the high write commits the whole pair.
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 4'h1, v[15:8]);
    endtask

    task automatic wait_sync();
        logic [7:0] v;
        int i;
        v = 8'hFF;
        for (i = 0; i < 100 && v[0] !== 1'b0; i++)
            rd(rtc_pkg::ADDR_SYNC_FLAG, v);
        chk({15'h0000, v[0]}, 16'h0000);
    endtask

    task automatic wait_ev(input int n);
        int base;
        int i;
        base = ovf_n;
        for (i = 0; i < 40000 && ovf_n - base < n; i++)
            @(posedge i_clk);
        #1;
    endtask

    logic [15:0] top_t [10] = '{16'h0, 16'h1, 16'h4, 16'h2, 16'h2, 16'h2, 16'h2, 16'h2,
        16'h2, 16'h2};
    logic [7:0] div_t [10] = '{8'h1, 8'h1, 8'h1, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5, 8'h6, 8'h7};
    logic [15:0] gap_t [10] = '{16'd3, 16'd4, 16'd5, 16'd3, 16'd6, 16'd24, 16'd48,
        16'd192, 16'd768, 16'd3072};

    initial
    begin
        int k;
        int mb;
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        rchk(rtc_pkg::ADDR_DIV_CTRL, 8'h00);
        rchk(rtc_pkg::ADDR_SYNC_FLAG, 8'h00);
        rchk(rtc_pkg::ADDR_IRQ_LEVEL, 8'h00);
        rchk(rtc_pkg::ADDR_IRQ_FLAG, 8'h00);
        rchk(4'h5, 8'h00);
        rchk(rtc_pkg::ADDR_TOP_LOW, 8'hFF);
        rchk(rtc_pkg::ADDR_TOP_HIGH, 8'hFF);
        rchk(rtc_pkg::ADDR_COUNT_LOW, 8'h00);
        // Top and match pairs read back byte-wise through the holding byte.
        wr16(rtc_pkg::ADDR_TOP_LOW, 16'h0304);
        #1;
        chk({15'h0000, o_sync_pending}, 16'h0001);
        rchk(rtc_pkg::ADDR_SYNC_FLAG, 8'h01);
        wait_sync();
        rchk(rtc_pkg::ADDR_TOP_LOW, 8'h04);
        rchk(rtc_pkg::ADDR_TOP_HIGH, 8'h03);
        wr16(rtc_pkg::ADDR_MATCH_LOW, 16'h0502);
        wait_sync();
        rchk(rtc_pkg::ADDR_MATCH_LOW, 8'h02);
        rchk(rtc_pkg::ADDR_MATCH_HIGH, 8'h05);
        wr16(rtc_pkg::ADDR_MATCH_LOW, 16'h0002);
        wait_sync();
        wr16(rtc_pkg::ADDR_COUNT_LOW, 16'h1203);
        wait_sync();
        rchk(rtc_pkg::ADDR_COUNT_LOW, 8'h03);
        rchk(rtc_pkg::ADDR_COUNT_HIGH, 8'h12);
        // Each row: stop, clear count, set top and divider, then time the events.
        for (k = 0; k < 10; k++)
        begin
            wr(rtc_pkg::ADDR_DIV_CTRL, 8'h00);
            wait_sync();
            wr16(rtc_pkg::ADDR_COUNT_LOW, 16'h0000);
            wait_sync();
            wr16(rtc_pkg::ADDR_TOP_LOW, top_t[k]);
            wait_sync();
            wr(rtc_pkg::ADDR_DIV_CTRL, div_t[k]);
            wait_sync();
            wait_ev(2);
            chk(gap, gap_t[k]);
            if (div_t[k] == 8'h1)
            begin
                mb = mat_n;
                wait_ev(3);
                chk(16'(mat_n - mb), (top_t[k] < 16'h2) ? 16'd0 : 16'd3);
            end
        end
        // Stopped counter with both flags left set from the last run.
        wr(rtc_pkg::ADDR_DIV_CTRL, 8'h00);
        wait_sync();
        rchk(rtc_pkg::ADDR_IRQ_FLAG, 8'h03);
        chk({15'h0000, o_irq}, 16'h0000);
        wr(rtc_pkg::ADDR_IRQ_LEVEL, 8'h05);
        repeat (3) @(posedge i_clk);
        #1;
        chk({15'h0000, o_irq}, 16'h0001);
        chk({8'h00, o_irq_vector}, {8'h00, rtc_pkg::OVERFLOW_VECTOR});
        wr(rtc_pkg::ADDR_IRQ_LEVEL, 8'h04);
        repeat (3) @(posedge i_clk);
        #1;
        chk({8'h00, o_irq_vector}, {8'h00, rtc_pkg::MATCH_VECTOR});
        wr(rtc_pkg::ADDR_IRQ_FLAG, 8'h02);
        rchk(rtc_pkg::ADDR_IRQ_FLAG, 8'h01);
        repeat (2) @(posedge i_clk);
        #1;
        chk({15'h0000, o_irq}, 16'h0000);
        // Run once more to set both flags, then clear the match flag by its vector.
        wr(rtc_pkg::ADDR_DIV_CTRL, 8'h01);
        wait_sync();
        wait_ev(1);
        wr(rtc_pkg::ADDR_DIV_CTRL, 8'h00);
        wait_sync();
        rchk(rtc_pkg::ADDR_IRQ_FLAG, 8'h03);
        @(posedge i_clk);
        i_match_vec_ack <= 1'b1;
        @(posedge i_clk);
        i_match_vec_ack <= 1'b0;
        rchk(rtc_pkg::ADDR_IRQ_FLAG, 8'h01);
        @(posedge i_clk);
        i_ovf_vec_ack <= 1'b1;
        @(posedge i_clk);
        i_ovf_vec_ack <= 1'b0;
        rchk(rtc_pkg::ADDR_IRQ_FLAG, 8'h00);
        repeat (200) @(posedge i_clk);
        rchk(rtc_pkg::ADDR_IRQ_FLAG, 8'h00);
        print_verdict();
    end
endmodule
